//--- core/sonv_mem.sv
`default_nettype none

// Nonvolatile array, read data registered one cycle after the request
module sonv_mem (
    input  wire logic mclk,
    input  wire logic rst,
    sonv_mem_if.mem   port
);
    import sonv_pkg::*;

    logic [15:0]  arr [256];
    sonv_mem_st_t s_r;
    sonv_mem_st_t s_nxt;

    // Contents are not reset: they model storage that survives power-down
    always_ff @(posedge mclk) begin
        if (port.en && port.we) begin
            arr[port.addr] <= port.wdata;
        end
    end

    always_comb begin
        s_nxt = s_r;
        if (port.en && !port.we) begin
            s_nxt.rdata_r = arr[port.addr];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign port.rdata = s_r.rdata_r;

endmodule : sonv_mem

`default_nettype wire

//--- core/sonv_regs.sv
`default_nettype none
`include "sonv_consts.svh"

module sonv_regs #(
    parameter int unsigned WRITE_CYCLES = `SONV_WRITE_CYCLES
) (
    input  wire logic                                mclk,
    input  wire logic                                rst,
    input  wire logic                                reg_wr,
    input  wire logic                                reg_rd,
    input  wire logic [7:0]                          reg_addr,
    input  wire logic [15:0]                         reg_wdata,
    output logic [15:0]                              reg_rdata,
    input  wire logic [`SONV_SPEED_CMD_W-1:0]        ext_speed,
    output logic [`SONV_SPEED_CMD_W-1:0]             speed_demand,
    output logic [15:0]                              nvm_read_data,
    output logic [`SONV_CFG_WORDS-1:0][15:0]         cfg_words
);
    import sonv_pkg::*;

    localparam logic [15:0] WAIT_LAST = 16'(WRITE_CYCLES - 1);
    localparam logic [2:0]  IDX_LAST  = 3'(`SONV_CFG_WORDS - 1);

    sonv_mem_if mif ();
    sonv_regs_t r;
    sonv_regs_t n;

    logic        unlocked;
    logic        in_cfg;
    logic [2:0]  cfg_idx;
    logic [7:0]  cur_addr;
    logic [2:0]  cur_idx;
    logic        cur_in_cfg;
    logic [15:0] cur_wdata;

    sonv_mem u_mem (
        .mclk (mclk),
        .rst  (rst),
        .port (mif.mem)
    );

    // Key compare and config window decode for the register port
    assign unlocked = (r.key_r == `SONV_UNLOCK_KEY);
    assign in_cfg   = (reg_addr >= `SONV_OFS_CFG_FIRST) &&
                      (reg_addr <= `SONV_OFS_CFG_LAST);
    assign cfg_idx  = 3'(reg_addr - `SONV_OFS_CFG_FIRST);

    // Target of the running operation: mass walks the window by index
    assign cur_addr   = r.mass_r ? 8'(`SONV_OFS_CFG_FIRST + r.idx_r)
                                 : r.saddr_r;
    assign cur_in_cfg = (cur_addr >= `SONV_OFS_CFG_FIRST) &&
                        (cur_addr <= `SONV_OFS_CFG_LAST);
    assign cur_idx    = 3'(cur_addr - `SONV_OFS_CFG_FIRST);
    assign cur_wdata  = r.mass_r ? r.shadow_w[r.idx_r] : r.wdata_r;

    // Array requests come straight from the sequencer state
    always_comb begin
        mif.en    = (r.st_r == SONV_RD) ||
                    ((r.st_r == SONV_WR) && (r.cnt_r == 16'h0000));
        mif.we    = (r.st_r == SONV_WR) && (r.cnt_r == 16'h0000);
        mif.addr  = cur_addr;
        mif.wdata = cur_wdata;
    end

    // Register writes, sequencer and read mux
    always_comb begin
        n = r;
        n.demand_r = r.ovr_r ? r.cmd_r : ext_speed;

        if (reg_wr) begin
            case (reg_addr)
                `SONV_OFS_SPEED: begin
                    n.ovr_r = reg_wdata[`SONV_SPEED_OVR_BIT];
                    n.cmd_r = reg_wdata[`SONV_SPEED_CMD_W-1:0];
                end
                `SONV_OFS_KEY:   n.key_r   = reg_wdata;
                `SONV_OFS_SADDR: n.saddr_r = reg_wdata[7:0];
                `SONV_OFS_WDATA: n.wdata_r = reg_wdata;
                `SONV_OFS_ACCESS: begin
                    n.shadow_r = reg_wdata[`SONV_ACC_SHADOW_BIT];
                    n.wnr_r    = reg_wdata[`SONV_ACC_WNR_BIT];
                    n.mode_r   = reg_wdata[`SONV_ACC_MODE_LSB+:2];
                end
                default: begin
                    // Shadow copies are writable only once unlocked
                    if (in_cfg && unlocked) begin
                        n.shadow_w[cfg_idx] = reg_wdata;
                    end
                end
            endcase
        end

        // Launch only from idle; commands while busy are dropped
        if (reg_wr && reg_addr == `SONV_OFS_ACCESS &&
            r.st_r == SONV_IDLE && unlocked) begin
            n.idx_r = 3'h0;
            n.cnt_r = 16'h0000;
            if (reg_wdata[`SONV_ACC_RELOAD_BIT]) begin
                // Set only on launch so a refused reload never sticks high
                n.reload_r = 1'b1;
                n.mass_r  = 1'b1;
                n.op_wr_r = 1'b0;
                n.st_r    = SONV_RD;
            end else begin
                case (reg_wdata[`SONV_ACC_MODE_LSB+:2])
                    `SONV_MODE_SINGLE: begin
                        n.mass_r  = 1'b0;
                        n.op_wr_r = reg_wdata[`SONV_ACC_WNR_BIT];
                        n.st_r    = reg_wdata[`SONV_ACC_WNR_BIT]
                                    ? SONV_WR : SONV_RD;
                    end
                    `SONV_MODE_MASS: begin
                        n.mass_r  = 1'b1;
                        n.op_wr_r = reg_wdata[`SONV_ACC_WNR_BIT];
                        n.st_r    = reg_wdata[`SONV_ACC_WNR_BIT]
                                    ? SONV_WR : SONV_RD;
                    end
                    default: n.st_r = SONV_IDLE; // Off and reserved
                endcase
            end
        end

        case (r.st_r)
            SONV_RD: n.st_r = SONV_RDW;
            SONV_RDW: begin
                if (r.mass_r) begin
                    n.shadow_w[r.idx_r] = mif.rdata;
                    n.live_w[r.idx_r]   = mif.rdata;
                end else begin
                    n.rd_data_r = mif.rdata;
                end
                if (r.mass_r && r.idx_r != IDX_LAST) begin
                    n.idx_r = r.idx_r + 3'h1;
                    n.st_r  = SONV_RD;
                end else begin
                    n.reload_r = 1'b0;
                    n.st_r     = SONV_IDLE;
                end
            end
            SONV_WR: begin
                // The array write is issued on the first wait cycle
                if (r.cnt_r == 16'h0000 && cur_in_cfg) begin
                    n.live_w[cur_idx] = cur_wdata;
                end
                if (r.cnt_r != WAIT_LAST) begin
                    n.cnt_r = r.cnt_r + 16'h0001;
                end else if (r.mass_r && r.idx_r != IDX_LAST) begin
                    n.cnt_r = 16'h0000;
                    n.idx_r = r.idx_r + 3'h1;
                end else begin
                    n.st_r = SONV_IDLE;
                end
            end
            default: ;
        endcase

        // Ready only while idle and no launch is pending
        n.ready_r = (n.st_r == SONV_IDLE);

        n.reg_rdata_r = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                `SONV_OFS_SPEED: n.reg_rdata_r =
                    {r.ovr_r, 6'h00, r.cmd_r};
                `SONV_OFS_KEY:   n.reg_rdata_r = r.key_r;
                `SONV_OFS_READY: n.reg_rdata_r = {15'h0000, r.ready_r};
                `SONV_OFS_SADDR: n.reg_rdata_r = {8'h00, r.saddr_r};
                `SONV_OFS_WDATA: n.reg_rdata_r = r.wdata_r;
                `SONV_OFS_ACCESS: n.reg_rdata_r =
                    {3'h0, r.shadow_r, 3'h0, r.reload_r,
                     5'h00, r.wnr_r, r.mode_r};
                default: begin
                    if (in_cfg && unlocked) begin
                        n.reg_rdata_r = r.shadow_r ? r.shadow_w[cfg_idx]
                                                   : r.live_w[cfg_idx];
                    end
                end
            endcase
        end
    end

    // Reset clears all bank state but not the array contents, ready rises the cycle after release
    always_ff @(posedge mclk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // Operating configuration follows the shadow only when selected
    genvar gi;
    generate
        for (gi = 0; gi < `SONV_CFG_WORDS; gi++) begin : g_cfg
            assign cfg_words[gi] = r.shadow_r ? r.shadow_w[gi]
                                              : r.live_w[gi];
        end
    endgenerate

    assign reg_rdata     = r.reg_rdata_r;
    assign speed_demand  = r.demand_r;
    assign nvm_read_data = r.rd_data_r;

endmodule : sonv_regs

`default_nettype wire

//--- shared/sonv_consts.svh
`ifndef SONV_CONSTS_SVH
`define SONV_CONSTS_SVH

// Register offsets on the chip register port
`define SONV_OFS_SPEED      8'h30
`define SONV_OFS_KEY        8'h31
`define SONV_OFS_READY      8'h32
`define SONV_OFS_SADDR      8'h33
`define SONV_OFS_WDATA      8'h34
`define SONV_OFS_ACCESS     8'h35
`define SONV_OFS_CFG_FIRST  8'h90
`define SONV_OFS_CFG_LAST   8'h96

// Field positions
`define SONV_SPEED_OVR_BIT  15
`define SONV_SPEED_CMD_W    9
`define SONV_ACC_SHADOW_BIT 12
`define SONV_ACC_RELOAD_BIT 8
`define SONV_ACC_WNR_BIT    2
`define SONV_ACC_MODE_LSB   0

// Access mode encodings
`define SONV_MODE_OFF       2'h0
`define SONV_MODE_SINGLE    2'h1
`define SONV_MODE_MASS      2'h2

// Key, reset values, counts
`define SONV_UNLOCK_KEY     16'hc0de
`define SONV_RST_WORD       16'h0000
`define SONV_CFG_WORDS      7
`define SONV_WRITE_CYCLES   16

`endif

//--- shared/sonv_mem_if.sv
`default_nettype none

// Port between the register bank and its nonvolatile array model
interface sonv_mem_if;
    logic        en;
    logic        we;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;

    modport ctrl (output en, output we, output addr, output wdata,
                  input rdata);
    modport mem  (input en, input we, input addr, input wdata,
                  output rdata);
endinterface : sonv_mem_if

`default_nettype wire

//--- shared/sonv_pkg.sv
`default_nettype none
`include "sonv_consts.svh"

package sonv_pkg;

    typedef enum logic [2:0] {
        SONV_IDLE,
        SONV_RD,
        SONV_RDW,
        SONV_WR
    } sonv_state_t;

    typedef logic [15:0] sonv_word_t;

    // Whole state of the register bank
    typedef struct packed {
        logic                                  ovr_r;
        logic [`SONV_SPEED_CMD_W-1:0]          cmd_r;
        logic [`SONV_SPEED_CMD_W-1:0]          demand_r;
        sonv_word_t                            key_r;
        logic                                  ready_r;
        logic [7:0]                            saddr_r;
        sonv_word_t                            wdata_r;
        logic                                  shadow_r;
        logic                                  reload_r;
        logic                                  wnr_r;
        logic [1:0]                            mode_r;
        sonv_state_t                           st_r;
        logic                                  mass_r;
        logic                                  op_wr_r;
        logic [2:0]                            idx_r;
        logic [15:0]                           cnt_r;
        sonv_word_t                            rd_data_r;
        sonv_word_t                            reg_rdata_r;
        logic [`SONV_CFG_WORDS-1:0][15:0]      shadow_w;
        logic [`SONV_CFG_WORDS-1:0][15:0]      live_w;
    } sonv_regs_t;

    typedef struct packed {
        sonv_word_t rdata_r;
    } sonv_mem_st_t;

endpackage : sonv_pkg

`default_nettype wire

//--- sim/sonv_host.sv
`default_nettype none
`include "sonv_consts.svh"

// Host side of the register port; one strobe cycle per access
module sonv_host (
    input  wire logic        mclk,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [7:0]       reg_addr,
    output logic [15:0]      reg_wdata,
    input  wire logic [15:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle bus from time zero
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge mclk) #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
        @(posedge mclk) #1 reg_wr = 1'b0;
    endtask : wr
    // Registered answer is settled just after the taking edge
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge mclk) #1 {reg_rd, reg_addr} = {1'b1, a};
        @(posedge mclk) #1 reg_rd = 1'b0;
        v = reg_rdata;
    endtask : rd
    // Polls the ready flag under a bound before any launch
    task automatic wait_ready(output logic ok);
        logic [15:0] s;
        ok = 1'b0;
        for (int i = 0; i < 200 && !ok; i++) begin
            rd(`SONV_OFS_READY, s);
            ok = s[0];
        end
    endtask : wait_ready
    task automatic launch(input logic [7:0] a, input logic [15:0] ctl);
        logic ok;
        wait_ready(ok);
        wr(`SONV_OFS_SADDR, {8'h00, a});
        wr(`SONV_OFS_ACCESS, ctl);
    endtask : launch
endmodule : sonv_host

`default_nettype wire

//--- sim/sonv_regs_checker.sv
`default_nettype none
`include "sonv_consts.svh"

// Judges port traffic against mirrors of what the host wrote
module sonv_regs_checker #(
    parameter int unsigned WRITE_CYCLES = 16
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic [8:0]  ext_speed,
    input wire logic [8:0]  speed_demand
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        ovr_m;
    logic [8:0]  cmd_m;
    logic [15:0] key_m;
    logic [15:0] wd_m;
    logic [7:0]  sa_m;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_rd(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    // Mirrors cleared with the design so reads right after reset agree
    always_ff @(posedge mclk) begin
        if (rst) begin
            {ovr_m, cmd_m, key_m, wd_m, sa_m} <= '0;
        end else if (reg_wr) begin
            if (reg_addr == `SONV_OFS_SPEED) begin
                ovr_m <= reg_wdata[15];
                cmd_m <= reg_wdata[8:0];
            end
            if (reg_addr == `SONV_OFS_KEY) key_m <= reg_wdata;
            if (reg_addr == `SONV_OFS_WDATA) wd_m <= reg_wdata;
            if (reg_addr == `SONV_OFS_SADDR) sa_m <= reg_wdata[7:0];
        end
    end
    a_speed_readback: assert property (
        s_rd(`SONV_OFS_SPEED) |=> reg_rdata == {ovr_m, 6'h00, cmd_m})
        else $error("speed word readback wrong");
    a_speed_host_cmd: assert property (
        ovr_m && $past(ovr_m) && $stable(cmd_m) |-> speed_demand == cmd_m)
        else $error("speed_enable_a active but demand differs");
    a_speed_ext_path: assert property (
        !ovr_m && !$past(ovr_m) && $stable(ext_speed)
        && ext_speed == $past(ext_speed, 2) |-> speed_demand == ext_speed)
        else $error("demand not following other source");
    a_key_readback: assert property (
        s_rd(`SONV_OFS_KEY) |=> reg_rdata == key_m)
        else $error("key readback wrong");
    a_locked_cfg_zero: assert property (
        key_m != `SONV_UNLOCK_KEY && reg_rd
        && reg_addr inside {[8'h90:8'h96]} |=> reg_rdata == 16'h0000)
        else $error("config space readable while locked");
    a_ready_reserved: assert property (
        s_rd(`SONV_OFS_READY) |=> reg_rdata[15:1] == 15'h0000)
        else $error("ready word upper bits set");
    a_saddr_readback: assert property (
        s_rd(`SONV_OFS_SADDR) |=> reg_rdata == {8'h00, sa_m})
        else $error("address readback wrong");
    a_wdata_readback: assert property (
        s_rd(`SONV_OFS_WDATA) |=> reg_rdata == wd_m)
        else $error("write data readback wrong");
endmodule : sonv_regs_checker

bind sonv_regs sonv_regs_checker #(.WRITE_CYCLES(WRITE_CYCLES)) i_chk (
    .mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .ext_speed(ext_speed), .speed_demand(speed_demand));

`default_nettype wire

//--- sim/speed_speed_enable_a_nvm_prog_regs_tb.sv
`default_nettype none
`include "sonv_consts.svh"

module speed_speed_enable_a_nvm_prog_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic                             mclk;
    logic                             rst;
    logic                             reg_wr;
    logic                             reg_rd;
    logic [7:0]                       reg_addr;
    logic [15:0]                      reg_wdata;
    logic [15:0]                      reg_rdata;
    logic [8:0]                       ext_speed;
    logic [8:0]                       speed_demand;
    logic [15:0]                      nvm_read_data;
    logic [`SONV_CFG_WORDS-1:0][15:0] cfg_words;
    logic [15:0]                      d;
    logic                             ok;
    int                               err_total;
    int                               comparisons;

    // Short write time keeps the run brief
    sonv_regs #(.WRITE_CYCLES(4)) i_sonv_regs (.mclk(mclk), .rst(rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .ext_speed(ext_speed), .speed_demand(speed_demand),
        .nvm_read_data(nvm_read_data), .cfg_words(cfg_words));
    sonv_host i_sonv_host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic conclude();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    // Reserved bits must read low; speed_enable_a then other source
    task automatic t_speed();
        i_sonv_host.wr(8'h30, 16'hffff);
        i_sonv_host.rd(8'h30, d);
        chk("speed word", 16'h81ff, d);
        repeat (3) @(posedge mclk);
        chk("host demand", 16'h01ff, {7'h00, speed_demand});
        #1 ext_speed = 9'h055;
        i_sonv_host.wr(8'h30, 16'h00a5);
        repeat (3) @(posedge mclk);
        chk("ext demand", 16'h0055, {7'h00, speed_demand});
        i_sonv_host.wr(8'h40, 16'h1111);
        i_sonv_host.rd(8'h40, d);
        chk("unmapped", 16'h0000, d);
    endtask : t_speed
    task automatic t_lock();
        i_sonv_host.wr(8'h90, 16'h5a5a);
        i_sonv_host.rd(8'h90, d);
        chk("locked cfg", 16'h0000, d);
        i_sonv_host.wr(8'h31, `SONV_UNLOCK_KEY);
        i_sonv_host.rd(8'h31, d);
        chk("key", `SONV_UNLOCK_KEY, d);
        i_sonv_host.rd(8'h90, d);
        chk("cfg after key", 16'h0000, d);
    endtask : t_lock
    // Write one word then read it back through the array
    task automatic t_single();
        i_sonv_host.wr(8'h34, 16'h1234);
        i_sonv_host.launch(8'h92, 16'h0005);
        i_sonv_host.rd(8'h32, d);
        chk("busy", 16'h0000, d);
        i_sonv_host.wait_ready(ok);
        chk("ready", 16'h0001, {15'h0, ok});
        chk("live word", 16'h1234, cfg_words[2]);
        i_sonv_host.launch(8'h92, 16'h0001);
        i_sonv_host.wait_ready(ok);
        chk("read data", 16'h1234, nvm_read_data);
    endtask : t_single
    task automatic t_shadow();
        i_sonv_host.wr(8'h35, 16'h1000);
        i_sonv_host.wr(8'h91, 16'hbeef);
        i_sonv_host.rd(8'h91, d);
        chk("shadow read", 16'hbeef, d);
        chk("shadow used", 16'hbeef, cfg_words[1]);
        i_sonv_host.launch(8'h92, 16'h1100);
        i_sonv_host.rd(8'h35, d);
        chk("reload pending", 16'h1100, d);
        i_sonv_host.wait_ready(ok);
        chk("reloaded", 16'h1234, cfg_words[2]);
        i_sonv_host.rd(8'h35, d);
        chk("reload done", 16'h1000, d);
    endtask : t_shadow
    // Shadow words go to the array in one mass pass, then show live
    task automatic t_mass();
        i_sonv_host.wr(8'h35, 16'h1000);
        for (int i = 0; i < `SONV_CFG_WORDS; i++) begin
            i_sonv_host.wr(8'(8'h90 + i), 16'ha000 + 16'(i));
        end
        i_sonv_host.launch(8'h90, 16'h1006);
        i_sonv_host.rd(8'h32, d);
        chk("mass busy", 16'h0000, d);
        i_sonv_host.wait_ready(ok);
        i_sonv_host.wr(8'h35, 16'h0000);
        for (int i = 0; i < `SONV_CFG_WORDS; i++) begin
            chk("mass word", 16'ha000 + 16'(i), cfg_words[i]);
        end
        i_sonv_host.launch(8'h95, 16'h0001);
        i_sonv_host.wait_ready(ok);
        chk("array word", 16'ha005, nvm_read_data);
    endtask : t_mass
    // Off and reserved modes start nothing; mass read goes busy
    task automatic t_modes();
        logic [15:0] ctl[3] = '{16'h1004, 16'h1007, 16'h0002};
        for (int i = 0; i < 3; i++) begin
            i_sonv_host.wr(8'h35, ctl[i]);
            i_sonv_host.rd(8'h32, d);
            chk("mode ready", {15'h0, i < 2}, d);
            i_sonv_host.wait_ready(ok);
        end
    endtask : t_modes

    // Free-running clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // Bounded run; a hang ends in the same verdict
    initial begin
        #400000;
        err_total++;
        conclude();
    end
    initial begin
        {err_total, comparisons} = '0;
        rst = 1'b1;
        ext_speed = 9'h000;
        repeat (6) @(posedge mclk);
        #1 rst = 1'b0;
        t_speed();
        t_lock();
        t_single();
        t_shadow();
        t_modes();
        t_mass();
        conclude();
    end
endmodule : speed_speed_enable_a_nvm_prog_regs_tb

`default_nettype wire
